// *** logic/flgar_regs.sv ***
`timescale 1ns/1ps

// What this block does
// - summary bit 0 is OR of latched flags
// - summary read leaves latched flags untouched
// - fourteen latched flags, upper bits read zero
// - enabled instantaneous fault sets and holds flag
// - clearing enable clears its latched flag
// - latched read clears flags, live faults reset
// - disabled fault reads zero latched from the cycle after its enable drops
// - pin 0 function: power-good, inverse, output, input
// - power-good high only without over/under faults
// - pin 1 function: dac-fault, inverse, output, input
// - dac-fault when either code at 00/FF
// - config pin high at reset clears data
// - control bit 6 mirrors alert pin level
// - alert asserts low on latched fault if enabled
// - test-write bit hands result registers to host
// - control bit 9 returns config pin level
// - bit 10 launches tracking, reads pending
// - conversion select bits enable seven sources
module flgar_regs #(
   parameter bit HAS_TRACKING = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host command port
   input flgar_pkg::flgar_cmd_t cmd,
   output flgar_pkg::flgar_rsp_t rsp,
   // monitor inputs
   input wire logic [flgar_pkg::FAULT_W-1:0] inst_fault,
   input wire logic [flgar_pkg::FAULT_W-1:0] fault_enable,
   input wire logic [7:0] chan0_dac_code,
   input wire logic [7:0] chan1_dac_code,
   // general pins, open drain
   input wire logic [flgar_pkg::PIN_N-1:0] gpin_in,
   output logic [flgar_pkg::PIN_N-1:0] gpin_out,
   output logic [flgar_pkg::PIN_N-1:0] gpin_oe_n,
   // alert pin, open drain, active low
   input wire logic alert_n_in,
   output logic alert_n_out,
   output logic alert_n_oe_n,
   // configuration pin
   input wire logic config_pin_in,
   // to the rest of the device
   output logic result_host_write_test,
   output logic tracking_launch,
   input wire logic tracking_pending,
   output logic [flgar_pkg::SRC_W-1:0] conv_select,
   input wire logic conv_advance,
   output logic [2:0] conv_source,
   output logic conv_active
);

   // pin synchronisers; left out of reset so they are settled at release
   logic [flgar_pkg::PIN_N-1:0] gpin_meta;
   logic [flgar_pkg::PIN_N-1:0] gpin_sync;
   logic alert_meta;
   logic alert_sync;
   logic cfg_meta;
   logic cfg_sync;

   always_ff @(posedge clk) begin
      gpin_meta <= gpin_in;
      gpin_sync <= gpin_meta;
      alert_meta <= alert_n_in;
      alert_sync <= alert_meta;
      cfg_meta <= config_pin_in;
      cfg_sync <= cfg_meta;
   end

   // state
   logic [flgar_pkg::FAULT_W-1:0] latched_fault_flags;
   logic [1:0] pin_fn [flgar_pkg::PIN_N];
   logic [flgar_pkg::PIN_N-1:0] pin_data;
   logic alert_disable;
   logic [flgar_pkg::SRC_W-1:0] conversion_source_select;
   logic strap_pending;

   // decode
   wire wr_summary = cmd.wr && cmd.code == flgar_pkg::CMD_SUMMARY;
   wire rd_latched = cmd.rd && cmd.code == flgar_pkg::CMD_LATCHED;
   wire wr_control = cmd.wr && cmd.code == flgar_pkg::CMD_CONTROL;
   wire wr_convsel = cmd.wr && cmd.code == flgar_pkg::CMD_CONVSEL;
   wire cmd_hit = cmd.code == flgar_pkg::CMD_SUMMARY || cmd.code == flgar_pkg::CMD_LATCHED
                  || cmd.code == flgar_pkg::CMD_CONTROL || cmd.code == flgar_pkg::CMD_CONVSEL;

   // latched faults
   wire [flgar_pkg::FAULT_W-1:0] fault_set = inst_fault & fault_enable;
   wire any_latched_fault = |latched_fault_flags;
   // a read clears held flags, but a fault seen in that same cycle is kept
   wire [flgar_pkg::FAULT_W-1:0] fault_hold = rd_latched ? '0 : latched_fault_flags;
   wire [flgar_pkg::FAULT_W-1:0] next_latched =
      (fault_hold | fault_set) & fault_enable;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         latched_fault_flags <= flgar_pkg::RST_LATCHED;
      end else begin
         latched_fault_flags <= next_latched;
      end
   end

   // derived levels
   wire power_good = ~|(inst_fault & flgar_pkg::OVUV_MASK);
   wire idac_fault = chan0_dac_code == flgar_pkg::IDAC_MIN
                     || chan0_dac_code == flgar_pkg::IDAC_MAX
                     || chan1_dac_code == flgar_pkg::IDAC_MIN
                     || chan1_dac_code == flgar_pkg::IDAC_MAX;
   wire [flgar_pkg::PIN_N-1:0] pin_level = {idac_fault, power_good};

   // general pin function select
   logic [flgar_pkg::PIN_N-1:0] pin_view;
   logic [flgar_pkg::PIN_N-1:0] pin_drive;

   for (genvar p = 0; p < flgar_pkg::PIN_N; p++) begin : g_pin
      always_comb begin
         unique case (pin_fn[p])
            flgar_pkg::FN_LEVEL: begin
               pin_view[p] = pin_level[p];
               pin_drive[p] = pin_level[p];
            end
            flgar_pkg::FN_LEVEL_N: begin
               pin_view[p] = ~pin_level[p];
               pin_drive[p] = ~pin_level[p];
            end
            flgar_pkg::FN_OUTPUT: begin
               pin_view[p] = pin_data[p];
               pin_drive[p] = pin_data[p];
            end
            flgar_pkg::FN_INPUT: begin
               pin_view[p] = gpin_sync[p];
               pin_drive[p] = 1'b1;
            end
         endcase
      end
      // open drain: pull low for a zero, otherwise let go
      assign gpin_out[p] = 1'b0;
      assign gpin_oe_n[p] = pin_drive[p];
   end

   // alert pin
   wire alert_assert = !alert_disable && any_latched_fault;
   assign alert_n_out = 1'b0;
   assign alert_n_oe_n = !alert_assert;

   // control register
   wire [15:0] wd = cmd.wdata;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_fn[0] <= flgar_pkg::RST_PIN_FN;
         pin_fn[1] <= flgar_pkg::RST_PIN_FN;
         pin_data <= {flgar_pkg::PIN_N{flgar_pkg::RST_PIN_DATA}};
         alert_disable <= flgar_pkg::RST_ALERT_DIS;
         result_host_write_test <= flgar_pkg::RST_TEST_WRITE;
         strap_pending <= 1'b1;
      end else begin
         strap_pending <= 1'b0;
         if (wr_control) begin
            pin_fn[0] <= wd[flgar_pkg::C_PIN0_FN +: 2];
            pin_fn[1] <= wd[flgar_pkg::C_PIN1_FN +: 2];
            pin_data[0] <= wd[flgar_pkg::C_PIN0_DATA];
            pin_data[1] <= wd[flgar_pkg::C_PIN1_DATA];
            alert_disable <= wd[flgar_pkg::C_ALERT_DIS];
            result_host_write_test <= wd[flgar_pkg::C_TEST_WRITE];
         end else if (strap_pending && cfg_sync) begin
            // strap caught on the first edge after release
            pin_data <= '0;
         end
      end
   end

   // one-cycle launch pulse; basic variant never launches
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tracking_launch <= 1'b0;
      end else begin
         tracking_launch <= HAS_TRACKING && wr_control && wd[flgar_pkg::C_TRACK];
      end
   end

   // conversion select
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conversion_source_select <= flgar_pkg::RST_CONVSEL;
      end else if (wr_convsel) begin
         conversion_source_select <= wd[flgar_pkg::SRC_W-1:0];
      end
   end

   assign conv_select = conversion_source_select;
   assign conv_active = |conversion_source_select;

   // round-robin source pointer, ascending with wrap
   logic [2:0] next_source;
   logic found;

   always_comb begin
      int idx;
      idx = 0;
      next_source = conv_source;
      found = 1'b0;
      for (int i = 1; i <= flgar_pkg::SRC_W; i++) begin
         idx = (int'(conv_source) + i) % flgar_pkg::SRC_W;
         if (!found && conversion_source_select[idx]) begin
            next_source = 3'(idx);
            found = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_source <= 3'h0;
      end else if (conv_advance || !conversion_source_select[conv_source]) begin
         // a deselected current source is dropped without waiting
         conv_source <= next_source;
      end
   end

   // read data
   logic [15:0] control_view;

   always_comb begin
      control_view = 16'h0000;
      control_view[flgar_pkg::C_PIN0_FN +: 2] = pin_fn[0];
      control_view[flgar_pkg::C_PIN1_FN +: 2] = pin_fn[1];
      control_view[flgar_pkg::C_PIN0_DATA] = pin_view[0];
      control_view[flgar_pkg::C_PIN1_DATA] = pin_view[1];
      control_view[flgar_pkg::C_ALERT_MIRROR] = alert_sync;
      control_view[flgar_pkg::C_ALERT_DIS] = alert_disable;
      control_view[flgar_pkg::C_TEST_WRITE] = result_host_write_test;
      control_view[flgar_pkg::C_CFG_LEVEL] = cfg_sync;
      control_view[flgar_pkg::C_TRACK] = HAS_TRACKING && tracking_pending;
   end

   logic [15:0] read_mux;

   always_comb begin
      read_mux = 16'h0000;
      if (cmd.code == flgar_pkg::CMD_SUMMARY) begin
         read_mux[0] = any_latched_fault;
      end else if (cmd.code == flgar_pkg::CMD_LATCHED) begin
         read_mux[flgar_pkg::FAULT_W-1:0] = latched_fault_flags;
      end else if (cmd.code == flgar_pkg::CMD_CONTROL) begin
         read_mux = control_view;
      end else if (cmd.code == flgar_pkg::CMD_CONVSEL) begin
         read_mux[flgar_pkg::SRC_W-1:0] = conversion_source_select;
      end
   end

   // the summary is read only; a write to it is answered without hit and dropped
   wire wr_dropped = wr_summary;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp <= '0;
      end else begin
         rsp.valid <= cmd.rd || cmd.wr;
         rsp.hit <= cmd_hit && !wr_dropped;
         rsp.data <= cmd.rd ? read_mux : 16'h0000;
      end
   end

endmodule : flgar_regs

// *** shared/flgar_pkg.sv ***
package flgar_pkg;

   // command codes of the four registers on the host command port
   localparam logic [7:0] CMD_SUMMARY = 8'h10;
   localparam logic [7:0] CMD_LATCHED = 8'h11;
   localparam logic [7:0] CMD_CONTROL = 8'h12;
   localparam logic [7:0] CMD_CONVSEL = 8'h13;

   localparam int FAULT_W = 14;
   localparam int SRC_W = 7;
   localparam int PIN_N = 2;

   // latched / instantaneous fault bit positions
   localparam int F_C0A_OV = 0;
   localparam int F_C0A_UV = 1;
   localparam int F_C0A_IDAC = 2;
   localparam int F_C0B_OV = 3;
   localparam int F_C0B_UV = 4;
   localparam int F_C1A_OV = 5;
   localparam int F_C1A_UV = 6;
   localparam int F_C1A_IDAC = 7;
   localparam int F_C1B_OV = 8;
   localparam int F_C1B_UV = 9;
   localparam int F_CORE_OV = 10;
   localparam int F_CORE_UV = 11;
   localparam int F_IN12_OV = 12;
   localparam int F_IN12_UV = 13;
   // over/under faults only; the two current-DAC fault bits are left out
   localparam logic [FAULT_W-1:0] OVUV_MASK = 14'h3F7B;

   // pin_alert_control field positions
   localparam int C_PIN0_FN = 0;
   localparam int C_PIN1_FN = 2;
   localparam int C_PIN0_DATA = 4;
   localparam int C_PIN1_DATA = 5;
   localparam int C_ALERT_MIRROR = 6;
   localparam int C_ALERT_DIS = 7;
   localparam int C_TEST_WRITE = 8;
   localparam int C_CFG_LEVEL = 9;
   localparam int C_TRACK = 10;

   // pin function codes
   localparam logic [1:0] FN_LEVEL = 2'h0;
   localparam logic [1:0] FN_LEVEL_N = 2'h1;
   localparam logic [1:0] FN_OUTPUT = 2'h2;
   localparam logic [1:0] FN_INPUT = 2'h3;

   // reset values
   localparam logic [1:0] RST_PIN_FN = FN_OUTPUT;
   localparam logic RST_PIN_DATA = 1'h1;
   localparam logic RST_ALERT_DIS = 1'h1;
   localparam logic RST_TEST_WRITE = 1'h0;
   localparam logic [SRC_W-1:0] RST_CONVSEL = 7'h00;
   localparam logic [FAULT_W-1:0] RST_LATCHED = 14'h0000;

   localparam logic [7:0] IDAC_MIN = 8'h00;
   localparam logic [7:0] IDAC_MAX = 8'hFF;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] code;
      logic [15:0] wdata;
   } flgar_cmd_t;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [15:0] data;
   } flgar_rsp_t;

endpackage : flgar_pkg

// *** test/flgar_regs_checker.sv ***
`timescale 1ns/1ps
module flgar_regs_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched ports
   input flgar_pkg::flgar_cmd_t cmd,
   input flgar_pkg::flgar_rsp_t rsp,
   input wire logic [13:0] fault_enable,
   input wire logic alert_n_oe_n,
   input wire logic result_host_write_test,
   input wire logic tracking_launch,
   input wire logic [6:0] conv_select,
   input wire logic [2:0] conv_source
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic rd_sum = cmd.rd && cmd.code == flgar_pkg::CMD_SUMMARY;
   wire logic rd_lat = cmd.rd && cmd.code == flgar_pkg::CMD_LATCHED;
   wire logic wr_ctl = cmd.wr && cmd.code == flgar_pkg::CMD_CONTROL;
   wire logic en_off = fault_enable == 14'h0000;
   chk_summary_upper: assert property (rd_sum |=> rsp.data[15:1] == 15'h0000)
      else $error("summary upper bits set");
   chk_latched_upper: assert property (rd_lat |=> rsp.data[15:14] == 2'h0)
      else $error("latched upper bits set");
   // enables held, so a second summary read may only keep or gain the flag
   chk_summary_keeps: assert property ((rd_sum && $stable(fault_enable))
      ##1 (!rd_lat && $stable(fault_enable)) ##1 rd_sum
      |=> rsp.data[0] || !$past(rsp.data[0], 2)) else $error("summary read cleared flags");
   chk_disabled_zero: assert property (rd_lat && en_off && $past(en_off)
      |=> rsp.data == 16'h0000) else $error("disabled flag latched");
   chk_alert_quiet: assert property (en_off |=> alert_n_oe_n)
      else $error("alert without latched fault");
   chk_track_pulse: assert property (wr_ctl && cmd.wdata[10] |=> tracking_launch)
      else $error("tracking launch missing");
   chk_track_only: assert property (!(wr_ctl && cmd.wdata[10]) |=> !tracking_launch)
      else $error("tracking launch unasked");
   chk_test_bit: assert property (wr_ctl |=> result_host_write_test == $past(cmd.wdata[8]))
      else $error("test write bit wrong");
   chk_source_selected: assert property (conv_select != 7'h00 && $stable(conv_select)
      |-> conv_select[conv_source]) else $error("unselected source visited");
   cover property (rd_lat ##1 rsp.data != 16'h0000);
   cover property (!alert_n_oe_n);
   cover property (tracking_launch);
endmodule : flgar_regs_checker

// *** test/flgar_host.sv ***
`timescale 1ns/1ps
module flgar_host (
   // clock
   input wire logic clk,
   // command port
   output flgar_pkg::flgar_cmd_t cmd,
   input flgar_pkg::flgar_rsp_t rsp
);
   initial cmd = '0;
   // idle code and data show the inverse so a stale value never looks valid
   task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] wd,
      output logic ok, output logic hit, output logic [15:0] rd);
      @(posedge clk);
      cmd <= '{wr: w, rd: !w, code: c, wdata: wd};
      @(posedge clk);
      cmd <= '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: ~wd};
      #1;
      ok = rsp.valid;
      hit = rsp.hit;
      rd = rsp.data;
   endtask : acc
endmodule : flgar_host

// *** test/fault_latch_gpio_alert_regs_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module fault_latch_gpio_alert_regs_tb_top;
   logic clk;
   logic rst_n;
   flgar_pkg::flgar_cmd_t cmd;
   flgar_pkg::flgar_rsp_t rsp;
   logic [13:0] inst_fault;
   logic [13:0] fault_enable;
   logic [7:0] dac0;
   logic [7:0] dac1;
   logic [1:0] pin_ext;
   logic cfg_pin;
   logic pending;
   logic advance;
   wire logic [1:0] oe_n;
   wire logic [1:0] pin_drv;
   // open drain: a released pin shows the outside level, a driven one what the block drives
   wire logic [1:0] pin_lvl = (oe_n & pin_ext) | (~oe_n & pin_drv);
   wire logic alert_oe_n;
   wire logic alert_drv;
   // alert line has a pull-up, so released means high
   wire logic alert_lvl = alert_oe_n | alert_drv;
   wire logic test_mode;
   wire logic launch;
   wire logic active;
   wire logic [6:0] sel;
   wire logic [2:0] src;
   logic ok;
   logic hit;
   logic [15:0] d;
   int fails = 0;
   int samples_checked = 0;
   flgar_regs u_dut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .inst_fault(inst_fault),
      .fault_enable(fault_enable), .chan0_dac_code(dac0), .chan1_dac_code(dac1),
      .gpin_in(pin_lvl), .gpin_out(pin_drv), .gpin_oe_n(oe_n), .alert_n_in(alert_lvl),
      .alert_n_out(alert_drv), .alert_n_oe_n(alert_oe_n), .config_pin_in(cfg_pin),
      .result_host_write_test(test_mode), .tracking_launch(launch),
      .tracking_pending(pending), .conv_select(sel), .conv_advance(advance),
      .conv_source(src), .conv_active(active));
   flgar_host u_host (.clk(clk), .cmd(cmd), .rsp(rsp));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      u_host.acc(1'b1, c, v, ok, hit, d);
      `CHK(ok, 1'b1)
   endtask : wr
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      u_host.acc(1'b0, c, 16'h0000, ok, hit, d);
      `CHK(ok, 1'b1)
      `CHK(hit, 1'b1)
      `CHK(d, e)
   endtask : rd
   task automatic pins(input int n, input logic [1:0] e);
      cyc(n);
      #1;
      `CHK(oe_n, e)
   endtask : pins
   task automatic t_strap();
      rd(flgar_pkg::CMD_CONTROL, 16'h02CA);
      `CHK(oe_n, 2'h0)
      rd(flgar_pkg::CMD_CONVSEL, 16'h0000);
      wr(flgar_pkg::CMD_SUMMARY, 16'hFFFF);
      `CHK(hit, 1'b0)
      wr(8'h20, 16'hFFFF);
      `CHK(hit, 1'b0)
      rd(flgar_pkg::CMD_SUMMARY, 16'h0000);
   endtask : t_strap
   task automatic t_pins();
      cfg_pin <= 1'b0;
      wr(flgar_pkg::CMD_CONTROL, 16'h00B0);
      pins(3, 2'h1);
      inst_fault <= 14'h0004;
      pins(3, 2'h1);
      inst_fault <= 14'h2000;
      dac1 <= 8'hFF;
      pins(3, 2'h2);
      wr(flgar_pkg::CMD_CONTROL, 16'h00B5);
      pins(2, 2'h1);
      inst_fault <= 14'h0000;
      dac1 <= 8'h80;
      dac0 <= 8'h00;
      pins(3, 2'h0);
      dac0 <= 8'h80;
      pin_ext <= 2'h2;
      wr(flgar_pkg::CMD_CONTROL, 16'h00BF);
      pins(4, 2'h3);
      rd(flgar_pkg::CMD_CONTROL, 16'h00EF);
      pin_ext <= 2'h3;
      wr(flgar_pkg::CMD_CONTROL, 16'h009A);
      pins(1, 2'h1);
   endtask : t_pins
   task automatic t_latch();
      fault_enable <= 14'h3FFB;
      inst_fault <= 14'h2005;
      @(posedge clk) inst_fault <= 14'h0000;
      rd(flgar_pkg::CMD_SUMMARY, 16'h0001);
      rd(flgar_pkg::CMD_SUMMARY, 16'h0001);
      rd(flgar_pkg::CMD_LATCHED, 16'h2001);
      rd(flgar_pkg::CMD_LATCHED, 16'h0000);
      inst_fault <= 14'h0020;
      rd(flgar_pkg::CMD_LATCHED, 16'h0020);
      rd(flgar_pkg::CMD_LATCHED, 16'h0020);
      `CHK(alert_oe_n, 1'b1)
      wr(flgar_pkg::CMD_CONTROL, 16'h001A);
      `CHK(alert_oe_n, 1'b0)
      cyc(2);
      rd(flgar_pkg::CMD_CONTROL, 16'h001A);
      fault_enable <= 14'h3FDB;
      rd(flgar_pkg::CMD_SUMMARY, 16'h0000);
      `CHK(alert_oe_n, 1'b1)
      inst_fault <= 14'h3FFF;
      fault_enable <= 14'h0000;
      rd(flgar_pkg::CMD_LATCHED, 16'h0000);
      inst_fault <= 14'h0000;
   endtask : t_latch
   task automatic t_track_conv();
      logic [2:0] nxt [3] = '{3'h4, 3'h6, 3'h1};
      pending <= 1'b1;
      wr(flgar_pkg::CMD_CONTROL, 16'h051A);
      `CHK(launch, 1'b1)
      `CHK(test_mode, 1'b1)
      rd(flgar_pkg::CMD_CONTROL, 16'h055A);
      pending <= 1'b0;
      wr(flgar_pkg::CMD_CONTROL, 16'h001A);
      `CHK(test_mode, 1'b0)
      wr(flgar_pkg::CMD_CONVSEL, 16'hFFFF);
      rd(flgar_pkg::CMD_CONVSEL, 16'h007F);
      wr(flgar_pkg::CMD_CONVSEL, 16'h0052);
      cyc(3);
      `CHK(active, 1'b1)
      `CHK(src, 3'h1)
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) advance <= 1'b1;
         @(posedge clk) advance <= 1'b0;
         @(posedge clk) #1;
         `CHK(src, nxt[i])
      end
      wr(flgar_pkg::CMD_CONVSEL, 16'h0000);
      `CHK(active, 1'b0)
   endtask : t_track_conv
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      inst_fault = 14'h0000;
      fault_enable = 14'h0000;
      dac0 = 8'h80;
      dac1 = 8'h80;
      pin_ext = 2'h3;
      cfg_pin = 1'b1;
      pending = 1'b0;
      advance = 1'b0;
      cyc(6);
      rst_n <= 1'b1;
      t_strap();
      t_pins();
      t_latch();
      t_track_conv();
      report_and_stop();
   end
endmodule : fault_latch_gpio_alert_regs_tb_top
bind flgar_regs flgar_regs_checker u_chk (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp),
   .fault_enable(fault_enable), .alert_n_oe_n(alert_n_oe_n),
   .result_host_write_test(result_host_write_test), .tracking_launch(tracking_launch),
   .conv_select(conv_select), .conv_source(conv_source));
